// *** verilog/cacsp_top.v ***
// Calibration converter command and status port behind the window registers.
// Assumes a serial converter that pulls ready low when a result is waiting.
`timescale 1ns/1ps
`include "cacsp_consts.vh"

module cacsp_top (
  input wire clock,
  input wire rst_n,
  input wire [7:0] win_addr,
  input wire win_wr,
  input wire win_rd,
  input wire [15:0] win_wdata,
  output reg [15:0] win_rdata_r,
  output wire adc_sclk,
  output wire adc_sdo,
  input wire adc_sdi,
  input wire adc_ready_n,
  output reg adc_cs_n_r
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_CMD = 3'd1;
  localparam [2:0] S_CFG = 3'd2;
  localparam [2:0] S_WAIT = 3'd3;
  localparam [2:0] S_CONV = 3'd4;

  // Sequencer state and host-visible registers
  reg [2:0] state_r;
  reg [7:0] cmd_r;
  reg [23:0] cfg_r;
  reg [15:0] result_r;
  reg ovr_r;
  reg osc_r;
  reg busy_r;
  reg cont_r;

  // Handshake to the shift engine
  reg start_r;
  reg [4:0] nbits_r;
  reg [23:0] tx_r;

  // Synchroniser stages for the converter pins
  reg sdi_m_r;
  reg sdi_s_r;
  reg rdy_m_r;
  reg rdy_s_r;

  // Shift engine results and decoded window strobes
  wire [23:0] rx;
  wire done;
  wire cmd_wr;
  wire cmd_take;
  wire cfg_hi_wr;
  wire cfg_lo_wr;

  // Does the window address match the given offset
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Window read multiplexer; write-only and unmapped offsets read zero
  function [15:0] read_mux;
    input [7:0] a;
    input [2:0] st;
    input [15:0] res;
    input [23:0] cfg;
    begin
      case (a)
        `CACSP_OFS_STATE: read_mux = {13'h0, st}; // [RQ5] [RQ6] [RQ7]
        `CACSP_OFS_RESULT: read_mux = res; // [RQ9]
        `CACSP_OFS_CFG_HIGH: read_mux = {8'h00, cfg[23:16]}; // [RQ11]
        `CACSP_OFS_CFG_LOW: read_mux = cfg[15:0]; // [RQ14]
        default: read_mux = 16'h0000;
      endcase
    end
  endfunction

  // Decoded window writes; a command without go is dropped here
  assign cmd_wr = win_wr && hit(win_addr, `CACSP_OFS_COMMAND) && win_wdata[`CACSP_CMD_GO];
  assign cfg_hi_wr = win_wr && hit(win_addr, `CACSP_OFS_CFG_HIGH);
  assign cfg_lo_wr = win_wr && hit(win_addr, `CACSP_OFS_CFG_LOW);

  // Commands are taken only in idle or while a single or continuous conversion waits for ready
  assign cmd_take = cmd_wr && (state_r == S_IDLE || state_r == S_WAIT); // [RQ8] [RQ4]

  // Two-stage synchronisers for converter pins
  always @(posedge clock) begin
    if (!rst_n) begin
      sdi_m_r <= 1'b0;
      sdi_s_r <= 1'b0;
      rdy_m_r <= 1'b1;
      rdy_s_r <= 1'b1;
    end else begin
      sdi_m_r <= adc_sdi;
      sdi_s_r <= sdi_m_r;
      rdy_m_r <= adc_ready_n;
      rdy_s_r <= rdy_m_r;
    end
  end

  cacsp_shift u_shift (
    .clock(clock),
    .rst_n(rst_n),
    .start(start_r),
    .nbits(nbits_r),
    .tx(tx_r),
    .sdi_s(sdi_s_r),
    .sclk_r(adc_sclk),
    .sdo_r(adc_sdo),
    .rx(rx),
    .done_r(done)
  );

  // Command sequencer
  always @(posedge clock) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      cmd_r <= `CACSP_RST_CMD;
      cfg_r <= `CACSP_RST_CFG;
      result_r <= `CACSP_RST_RESULT;
      ovr_r <= 1'b0;
      osc_r <= 1'b0;
      busy_r <= 1'b0;
      cont_r <= 1'b0;
      start_r <= 1'b0;
      nbits_r <= 5'd0;
      tx_r <= 24'h000000;
      adc_cs_n_r <= 1'b1;
    end else begin
      start_r <= 1'b0;
      // Host config writes; only legal while busy is 0
      if (cfg_hi_wr) begin
        cfg_r[23:16] <= win_wdata[7:0]; // [RQ11] [RQ13]
      end
      if (cfg_lo_wr) begin
        cfg_r[15:0] <= win_wdata; // [RQ14] [RQ13]
      end
      if (cmd_take) begin
        // New command; in continuous mode it ends that mode
        cmd_r <= win_wdata[7:0];
        cont_r <= 1'b0; // [RQ4]
        busy_r <= 1'b1; // [RQ7] [RQ8]
        tx_r <= {16'h0000, win_wdata[7:0]};
        nbits_r <= `CACSP_BITS_CMD;
        start_r <= 1'b1; // [RQ1]
        adc_cs_n_r <= 1'b0;
        state_r <= S_CMD;
      end else begin
        case (state_r)
          S_IDLE: begin
            adc_cs_n_r <= 1'b1;
          end
          S_CMD: begin
            if (done) begin
              if (cmd_r[`CACSP_CMD_CONT]) begin
                cont_r <= 1'b1; // [RQ2]
                busy_r <= 1'b1;
                state_r <= S_WAIT;
              end else if (cmd_r[`CACSP_CMD_SINGLE]) begin
                state_r <= S_WAIT; // [RQ15]
              end else begin
                // Register access: bit 4 reads, selector travels in the byte
                tx_r <= cfg_r; // [RQ12] [RQ16]
                nbits_r <= `CACSP_BITS_CFG;
                start_r <= 1'b1;
                state_r <= S_CFG;
              end
            end
          end
          S_CFG: begin
            if (done) begin
              if (cmd_r[`CACSP_CMD_READ]) begin
                cfg_r <= rx; // [RQ12] [RQ16]
              end
              cmd_r[`CACSP_CMD_GO] <= 1'b0; // [RQ17]
              busy_r <= 1'b0; // [RQ8]
              state_r <= S_IDLE;
            end
          end
          S_WAIT: begin
            if (!rdy_s_r) begin
              busy_r <= 1'b1; // [RQ7]
              tx_r <= 24'h000000;
              nbits_r <= `CACSP_BITS_CONV;
              start_r <= 1'b1;
              state_r <= S_CONV;
            end
          end
          S_CONV: begin
            if (done) begin
              // Frame is 16 data bits then overrange then oscillation
              result_r <= rx[17:2]; // [RQ9]
              ovr_r <= rx[1]; // [RQ5]
              osc_r <= rx[0]; // [RQ6]
              busy_r <= 1'b0; // [RQ3] [RQ8]
              if (cont_r) begin
                state_r <= S_WAIT; // [RQ3]
              end else begin
                cmd_r[`CACSP_CMD_GO] <= 1'b0; // [RQ17]
                state_r <= S_IDLE;
              end
            end
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Registered read port; data stand until the next read
  always @(posedge clock) begin
    if (!rst_n) begin
      win_rdata_r <= 16'h0000;
    end else if (win_rd) begin
      win_rdata_r <= read_mux(win_addr, {ovr_r, osc_r, busy_r}, result_r, cfg_r);
    end
  end

endmodule // cacsp_top

// *** verilog/cacsp_consts.vh ***
// Constants for the calibration converter command and status port.
// Assumes a 100 MHz clock and a serial converter with a ready-low pin.
// Overview of operation
// [RQ1] A written command byte is shifted out serially to the converter.
// [RQ2] Go plus continuous-convert puts the converter into continuous conversion.
// [RQ3] In continuous mode the newest result is readable whenever busy reads 0.
// [RQ4] Host leaves continuous mode by issuing another command with go set.
// [RQ5] Status bit 2 shows overrange; cleared by an error-free conversion.
// [RQ6] Status bit 1 shows oscillation detect; cleared by an error-free conversion.
// [RQ7] Status bit 0 reads 1 while the converter works on its latest task.
// [RQ8] Busy reads 0 when a new command may be taken; host waits for it.
// [RQ9] Conversion data register returns the 16-bit serial result, read-only.
// [RQ10] Host reads conversion data only while busy is 0.
// [RQ11] Config high register keeps config bits 23-16; upper bits reserved.
// [RQ12] High and low config words form 24 bits moved to or from converter.
// [RQ13] Host touches config data only while busy is 0.
// [RQ14] Config low register holds the low sixteen config bits.
// [RQ15] Go plus single-convert runs one conversion with busy high until done.
// [RQ16] Command bit 4 picks read or write; bits 3-1 pick the target register.
// [RQ17] The go bit clears itself once the command has finished executing.
`ifndef CACSP_CONSTS_VH
`define CACSP_CONSTS_VH

// Window offsets
`define CACSP_OFS_COMMAND 8'h19
`define CACSP_OFS_STATE 8'h1a
`define CACSP_OFS_RESULT 8'h1b
`define CACSP_OFS_CFG_HIGH 8'h1c
`define CACSP_OFS_CFG_LOW 8'h1d

// Command byte fields
`define CACSP_CMD_GO 7
`define CACSP_CMD_SINGLE 6
`define CACSP_CMD_CONT 5
`define CACSP_CMD_READ 4
`define CACSP_CMD_SEL_HI 3
`define CACSP_CMD_SEL_LO 1
`define CACSP_CMD_PSAVE 0

// Status bit positions
`define CACSP_ST_BUSY 0
`define CACSP_ST_OSC 1
`define CACSP_ST_OVR 2

// Reset values
`define CACSP_RST_CMD 8'h00
`define CACSP_RST_CFG 24'h000000
`define CACSP_RST_RESULT 16'h0000

// Frame lengths in serial bits
`define CACSP_BITS_CMD 5'd8
`define CACSP_BITS_CFG 5'd24
`define CACSP_BITS_CONV 5'd18

// Serial clock half period
`define CACSP_HALF_NS 40
`define CACSP_CLK_NS 10
`define CACSP_HALF_CYC ((`CACSP_HALF_NS + `CACSP_CLK_NS - 1) / `CACSP_CLK_NS)

`endif

// *** verilog/cacsp_shift.v ***
// Serial shift engine: moves up to 24 bits MSB first on a divided clock.
// Assumes sdi_s is already synchronised to clock.
`timescale 1ns/1ps
`include "cacsp_consts.vh"

module cacsp_shift (
  input wire clock,
  input wire rst_n,
  input wire start,
  input wire [4:0] nbits,
  input wire [23:0] tx,
  input wire sdi_s,
  output reg sclk_r,
  output reg sdo_r,
  output wire [23:0] rx,
  output reg done_r
);

  localparam integer HALF_CYC = `CACSP_HALF_CYC;
  localparam [3:0] HALF = HALF_CYC[3:0];

  reg [23:0] shreg_r;
  reg [4:0] cnt_r;
  reg [3:0] div_r;
  reg active_r;

  assign rx = shreg_r;

  // Drive data while low, sample on the end of the high phase
  always @(posedge clock) begin
    if (!rst_n) begin
      shreg_r <= 24'h000000;
      cnt_r <= 5'd0;
      div_r <= 4'h0;
      active_r <= 1'b0;
      sclk_r <= 1'b0;
      sdo_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !active_r) begin
        shreg_r <= tx << (5'd24 - nbits);
        sdo_r <= 1'b0;
        cnt_r <= nbits;
        div_r <= 4'h0;
        active_r <= 1'b1;
        sclk_r <= 1'b0;
      end else if (active_r) begin
        if (div_r == 4'h0 && !sclk_r) begin
          sdo_r <= shreg_r[23];
        end
        if (div_r == HALF - 4'h1) begin
          div_r <= 4'h0;
          sclk_r <= ~sclk_r;
          if (sclk_r) begin
            shreg_r <= {shreg_r[22:0], sdi_s};
            cnt_r <= cnt_r - 5'd1;
            if (cnt_r == 5'd1) begin
              active_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end else begin
          div_r <= div_r + 4'h1;
        end
      end
    end
  end

endmodule // cacsp_shift

// *** bench/cacsp_adc_model.sv ***
// Behavioural serial converter on the port's serial pins.
// Assumes MSB-first frames, host bits taken on rising sclk.
`timescale 1ns/1ps

module cacsp_adc_model (
  input wire sclk,
  input wire sdo,
  input wire cs_n,
  output reg sdi = 0,
  output reg ready_n = 1
);
  reg [7:0] cmd;
  reg [17:0] conv;
  reg [23:0] regv;
  reg armed = 0;
  integer n = 0, ph = 1, lat = 20;
  time due;
  // Ready drops once the conversion delay runs out
  always #10 if (armed && $time >= due) begin
    ready_n = 0;
    armed = 0;
  end
  // Deselect frees the data line, which then shows its inverse
  always @(posedge cs_n) begin
    sdi = ~sdi;
    ready_n = 1;
    armed = 0;
    ph = 1;
    n = 0;
  end
  // One bit per rising sclk; a rise while idle opens a command
  always @(posedge sclk) begin
    if (ph == 1 && n == 0 && ready_n) ph = 0;
    armed = armed && ph != 0;
    n = n + 1;
    if (ph == 0) cmd = {cmd[6:0], sdo};
    else if (ph == 1) {ready_n, sdi} = {1'b1, conv[18 - n]};
    else if (ph == 2) sdi = regv[24 - n];
    else regv = {regv[22:0], sdo};
    if (n == (ph == 0 ? 8 : ph == 1 ? 18 : 24)) begin
      armed = ph == 0 ? cmd[6] | cmd[5] : ph == 1 && cmd[5];
      conv = conv + (ph == 1 ? 18'h4 : 18'h0);
      ph = ph != 0 ? 1 : cmd[6] | cmd[5] ? 1 : cmd[4] ? 2 : 3;
      due = $time + lat;
      n = 0;
    end
  end
endmodule // cacsp_adc_model

// *** bench/cacsp_top_asserts.sv ***
// Checker on the port's window and serial pins.
// Assumes a 4-cycle serial half period and registered read data.
`timescale 1ns/1ps

module cacsp_top_asserts (
  input wire clock,
  input wire rst_n,
  input wire [7:0] win_addr,
  input wire win_wr,
  input wire win_rd,
  input wire [15:0] win_wdata,
  input wire [15:0] win_rdata_r,
  input wire adc_sclk,
  input wire adc_sdo,
  input wire adc_cs_n_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Command write on an idle link; window read of one place
  sequence s_cmd; win_wr && win_addr == 8'h19 && adc_cs_n_r; endsequence
  sequence s_rd(a); win_rd && win_addr == a; endsequence
  property p_go_sel; s_cmd ##0 win_wdata[7] |=> !adc_cs_n_r; endproperty
  a_go_sel: assert property (p_go_sel) else $error("select lost");
  property p_no_go; s_cmd ##0 !win_wdata[7] |=> adc_cs_n_r; endproperty
  a_no_go: assert property (p_no_go) else $error("no-go ran");
  property p_sclk_high; $rose(adc_sclk) |-> adc_sclk [*4] ##1 !adc_sclk; endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("sclk high");
  property p_sdo_hold; adc_sclk && $past(adc_sclk) |-> $stable(adc_sdo); endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved");
  property p_st_res; s_rd(8'h1a) |=> win_rdata_r[15:3] == 13'h0; endproperty
  a_st_res: assert property (p_st_res) else $error("status bits");
  property p_idle; s_rd(8'h1a) ##0 adc_cs_n_r && $past(adc_cs_n_r) |=> !win_rdata_r[0]; endproperty
  a_idle: assert property (p_idle) else $error("busy idle");
  property p_cfg_res; s_rd(8'h1c) |=> win_rdata_r[15:8] == 8'h00; endproperty
  a_cfg_res: assert property (p_cfg_res) else $error("cfg high");
  property p_hold; !win_rd |=> $stable(win_rdata_r); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
endmodule // cacsp_top_asserts

bind cacsp_top cacsp_top_asserts u_cacsp_top_asserts (.clock(clock), .rst_n(rst_n),
  .win_addr(win_addr), .win_wr(win_wr), .win_rd(win_rd), .win_wdata(win_wdata),
  .win_rdata_r(win_rdata_r), .adc_sclk(adc_sclk), .adc_sdo(adc_sdo), .adc_cs_n_r(adc_cs_n_r));

// *** bench/cacsp_top_tb.sv ***
// Bench for the port: window task, converter model, scenarios.
// Assumes the model and the bound checker are compiled with it.
`timescale 1ns/1ps

module cacsp_top_tb;
  reg clock = 0;
  reg rst_n = 0;
  reg win_wr = 0;
  reg win_rd = 0;
  reg [7:0] win_addr = 8'h00;
  reg [15:0] win_wdata = 16'h0;
  reg [17:0] c;
  wire [15:0] d;
  wire sclk, sdo, sdi, ready_n, cs_n;
  integer fails = 0, compares = 0, i, k;
  always #5 clock = ~clock;
  cacsp_top u_cacsp_top (.clock(clock), .rst_n(rst_n), .win_addr(win_addr), .win_wr(win_wr),
    .win_rd(win_rd), .win_wdata(win_wdata), .win_rdata_r(d), .adc_sclk(sclk), .adc_sdo(sdo),
    .adc_sdi(sdi), .adc_ready_n(ready_n), .adc_cs_n_r(cs_n));
  cacsp_adc_model u_cacsp_adc_model (.sclk(sclk), .sdo(sdo), .cs_n(cs_n), .sdi(sdi),
    .ready_n(ready_n));
  // Count a comparison, report a difference
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One-cycle window strobe; read data is settled on return
  task acc(input w, input [7:0] a, input [15:0] v);
    begin
      @(posedge clock) #1;
      {win_wr, win_rd, win_addr, win_wdata} = {w, !w, a, v};
      @(posedge clock) #1;
      {win_wr, win_rd} = 2'b00;
    end
  endtask
  // Poll busy until it reads b, bounded
  task wait_busy(input b);
    begin
      k = 0;
      acc(0, 8'h1a, 16'h0);
      while (d[0] !== b && k < 600) begin
        acc(0, 8'h1a, 16'h0);
        k = k + 1;
      end
      chk(d[0], b);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Watchdog at about ten times the expected run
  initial begin
    #200000;
    fails = fails + 1;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge clock);
    #1 rst_n = 1;
    // Everything reads 0 after reset; a command without go starts nothing
    for (i = 8'h19; i < 8'h1e; i = i + 1) begin
      acc(0, i[7:0], 16'h0);
      chk(d, 16'h0);
    end
    acc(1, 8'h19, 16'h0060);
    acc(0, 8'h1a, 16'h0);
    chk(d, 16'h0);
    // Config words, register write, then register read
    acc(1, 8'h1c, 16'hffab);
    acc(1, 8'h1d, 16'h1234);
    acc(0, 8'h1c, 16'h0);
    chk(d, 16'h00ab);
    acc(1, 8'h19, 16'h0082);
    wait_busy(0);
    chk(u_cacsp_adc_model.regv, 24'hab1234);
    u_cacsp_adc_model.regv = 24'h5a6b7c;
    acc(1, 8'h19, 16'h0094);
    wait_busy(0);
    acc(0, 8'h1c, 16'h0);
    chk(d, 16'h005a);
    acc(0, 8'h1d, 16'h0);
    chk(d, 16'h6b7c);
    // Single conversions: overrange, oscillation, then clean
    for (i = 0; i < 3; i = i + 1) begin
      c = {16'h1357 + i[15:0], 2'b10 >> i};
      u_cacsp_adc_model.conv = c;
      acc(1, 8'h19, 16'h00c0);
      acc(0, 8'h1a, 16'h0);
      chk(d[0], 1'b1);
      wait_busy(0);
      acc(1, 8'h1b, 16'hffff);
      acc(0, 8'h1b, 16'h0);
      chk(d, c[17:2]);
      acc(0, 8'h1a, 16'h0);
      chk(d[2:1], c[1:0]);
    end
    // Continuous mode on a slow converter, then leave it by a single
    u_cacsp_adc_model.lat = 400;
    u_cacsp_adc_model.conv = {16'h0100, 2'b00};
    acc(1, 8'h19, 16'h00a0);
    for (i = 0; i < 3; i = i + 1) begin
      if (i == 2) u_cacsp_adc_model.conv = {16'h0777, 2'b00};
      if (i == 2) acc(1, 8'h19, 16'h00c0);
      wait (!ready_n);
      wait_busy(1);
      wait_busy(0);
      acc(0, 8'h1b, 16'h0);
      chk(d, i == 2 ? 16'h0777 : 16'h0100 + i[15:0]);
    end
    chk(cs_n, 1'b1);
    tally_and_finish;
  end
endmodule // cacsp_top_tb
